// ---- logic/tcem_pkg.sv ----
/*
  Constants for the ternary code error monitor.
  Assumes a 125 MHz system clock; times are given in nanoseconds.
*/
package tcem_pkg;
  localparam int          STAGES        = 5;
  localparam logic [4:0]  BAL_RESET     = 5'h00;
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          STRETCH_NS    = 700;
  localparam int          STRETCH_CYC   = (STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ABSENT_SYMS   = 64;
endpackage

// ---- logic/tcem_monitor.sv ----
/*
  Ternary code error monitor: balance register over a three-level line
  code, fast and stretched error outputs, pulse-absence indications.
  Assumes the line receiver delivers comparator levels from another
  domain (synchronised here) and a symbol strobe sampled the same way.
*/
// Operation
// - Classify symbol positive, negative or zero
// - Positive pulse trailing edge shifts toward five
// - Shift toward five inserts one at one
// - Negative pulse shifts toward stage one
// - Shift toward one inserts zero at five
// - Stage five one plus positive flags error
// - Stage one zero plus negative flags error
// - Legal values are six thermometer codes
// - Tolerate illegal start values until recovery
// - Fast error plus stretched error near 0.7us
// - Report missing positive and negative pulses
`timescale 1ns/1ns
module tcem_monitor
#(
  parameter int STRETCH = tcem_pkg::STRETCH_CYC,
  parameter int ABSENT  = tcem_pkg::ABSENT_SYMS
)
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       above_upper_i,
  input  wire logic       below_lower_i,
  input  wire logic       sym_strobe_i,
  output logic            fast_err_o,
  output logic            stretch_err_o,
  output logic            pos_absent_o,
  output logic            neg_absent_o,
  output logic [4:0]      balance_o
);
  import tcem_pkg::*;

  // Two-stage synchronisers for the line-side levels
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end
    else if (ce_i)
    begin
      sync1_r <= {sym_strobe_i, below_lower_i, above_upper_i};
      sync2_r <= sync1_r;
    end
  end

  // Symbol class; upper wins if a glitch shows both
  logic pos_lvl;
  logic neg_lvl;
  assign pos_lvl = sync2_r[0];
  assign neg_lvl = sync2_r[1] & ~sync2_r[0];

  // Edge detection on the detections and the strobe
  logic pos_d_r;
  logic neg_d_r;
  logic stb_d_r;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pos_d_r <= 1'b0;
      neg_d_r <= 1'b0;
      stb_d_r <= 1'b0;
    end
    else if (ce_i)
    begin
      pos_d_r <= pos_lvl;
      neg_d_r <= neg_lvl;
      stb_d_r <= sync2_r[2];
    end
  end

  logic pos_fall;
  logic neg_rise;
  logic stb_rise;
  assign pos_fall = pos_d_r & ~pos_lvl;
  assign neg_rise = neg_lvl & ~neg_d_r;
  assign stb_rise = sync2_r[2] & ~stb_d_r;

  // Balance register; no check of legality, so odd power-up patterns
  // simply shift out as pulses arrive
  logic [4:0] bal_r;
  logic [4:0] bal_nxt;
  always_comb
  begin
    bal_nxt = bal_r;
    if (pos_fall)
      bal_nxt = {bal_r[3:0], 1'b1};
    else if (neg_rise)
      bal_nxt = {1'b0, bal_r[4:1]};
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      bal_r <= BAL_RESET;
    else if (ce_i)
      bal_r <= bal_nxt;
  end

  // Violation at detection onset, judged on the register before shift
  logic pos_rise;
  logic err_now;
  assign pos_rise = pos_lvl & ~pos_d_r;
  assign err_now  = (pos_rise & bal_r[4]) |
                    (neg_rise & ~bal_r[0]);

  // Fast error: one cycle per violating symbol
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      fast_err_o <= 1'b0;
    else if (ce_i)
      fast_err_o <= err_now;
  end

  // Stretched error: retriggerable, so bursts merge into one long pulse
  logic [15:0] str_cnt_r;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      str_cnt_r     <= 16'h0000;
      stretch_err_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (err_now)
      begin
        str_cnt_r     <= 16'(STRETCH);
        stretch_err_o <= 1'b1;
      end
      else if (str_cnt_r > 16'h0001)
        str_cnt_r <= str_cnt_r - 16'h0001;
      else
      begin
        str_cnt_r     <= 16'h0000;
        stretch_err_o <= 1'b0;
      end
    end
  end

  // Absence counters in symbol periods, each restarted by a pulse of its own polarity
  logic [15:0] pos_cnt_r;
  logic [15:0] neg_cnt_r;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pos_cnt_r    <= 16'h0000;
      neg_cnt_r    <= 16'h0000;
      pos_absent_o <= 1'b0;
      neg_absent_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (pos_rise)
      begin
        pos_cnt_r    <= 16'h0000;
        pos_absent_o <= 1'b0;
      end
      else if (stb_rise && pos_cnt_r < 16'(ABSENT))
        pos_cnt_r <= pos_cnt_r + 16'h0001;
      else if (pos_cnt_r >= 16'(ABSENT))
        pos_absent_o <= 1'b1;
      if (neg_rise)
      begin
        neg_cnt_r    <= 16'h0000;
        neg_absent_o <= 1'b0;
      end
      else if (stb_rise && neg_cnt_r < 16'(ABSENT))
        neg_cnt_r <= neg_cnt_r + 16'h0001;
      else if (neg_cnt_r >= 16'(ABSENT))
        neg_absent_o <= 1'b1;
    end
  end

  // Register mirror for observation
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      balance_o <= BAL_RESET;
    else if (ce_i)
      balance_o <= bal_nxt;
  end

  a_pos_shift: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && pos_fall |=> bal_r == {$past(bal_r[3:0]), 1'b1})
    else $error("positive shift wrong");
  a_neg_shift: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && neg_rise && !pos_fall |=> bal_r == {1'b0, $past(bal_r[4:1])})
    else $error("negative shift wrong");
  a_hold_bal: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && !pos_fall && !neg_rise |=> $stable(bal_r))
    else $error("balance moved without pulse");
  a_err_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && pos_rise && bal_r[4] |=> fast_err_o && stretch_err_o)
    else $error("upper overflow not flagged");
  a_err_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && neg_rise && !bal_r[0] |=> fast_err_o)
    else $error("lower overflow not flagged");
  a_no_false: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && !err_now |=> !fast_err_o)
    else $error("spurious fast error");
  a_stretch_len: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(fast_err_o) && ce_i |-> stretch_err_o && str_cnt_r == 16'(STRETCH))
    else $error("stretch not loaded");
  a_legal_stay: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bal_r & (bal_r + 5'h01)) == 5'h00 |=> (bal_r & (bal_r + 5'h01)) == 5'h00)
    else $error("left thermometer codes");
  a_pos_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && pos_rise |=> !pos_absent_o && pos_cnt_r == 16'h0000)
    else $error("positive absence not cleared");
endmodule

// ---- tb/ternary_line_model.sv ----
/*
  Line-side model: comparator levels and a free-running symbol strobe.
  Assumes the bench clock; all changes are made at its rising edge.
*/
`timescale 1ns/1ns
module ternary_line_model
(
  input  wire logic clk_i,
  output logic      above_o,
  output logic      below_o,
  output logic      strobe_o
);
  // Quiet line at time zero
  initial
  begin
    above_o  = 1'b0;
    below_o  = 1'b0;
    strobe_o = 1'b0;
  end
  // Symbol clock runs free, as a recovered line clock does
  always @(posedge clk_i)
  begin
    strobe_o <= ~strobe_o;
  end
  // One symbol pulse, three cycles high and three low for margin
  task automatic send(input logic pos);
    @(posedge clk_i);
    if (pos) above_o <= 1'b1;
    else below_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    above_o <= 1'b0;
    below_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

// ---- tb/tb_tcem_monitor.sv ----
/*
  Self-checking bench for the ternary code error monitor.
  Assumes short STRETCH and ABSENT values so the run stays brief.
*/
`timescale 1ns/1ns
module tb_tcem_monitor;
  logic       sys_clk_i;
  logic       rst_i;
  logic       above, below, strobe;
  logic       fast_err, str_err, pos_abs, neg_abs;
  logic [4:0] bal;
  logic       ce;
  logic       clr_req = 1'b0;
  logic       err_seen = 1'b0;
  logic       str_seen = 1'b0;
  int         fail_count = 0;
  int         n_checks = 0;

  // Clock, 8 ns period
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  ternary_line_model line (.clk_i(sys_clk_i), .above_o(above), .below_o(below),
                           .strobe_o(strobe));
  tcem_monitor #(.STRETCH(4), .ABSENT(16)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .ce_i(ce), .above_upper_i(above), .below_lower_i(below), .sym_strobe_i(strobe),
    .fast_err_o(fast_err), .stretch_err_o(str_err), .pos_absent_o(pos_abs),
    .neg_absent_o(neg_abs), .balance_o(bal));

  // Fast error lasts one cycle, so it is latched here to be judged later
  // Only this process writes the latches, so a clear is a request here
  always @(posedge sys_clk_i)
  begin
    if (clr_req)
    begin
      err_seen <= 1'b0;
      str_seen <= 1'b0;
    end
    else
    begin
      if (fast_err) err_seen <= 1'b1;
      if (str_err) str_seen <= 1'b1;
    end
  end

  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Send pulses, then let the three-edge path settle
  task automatic pulses(input int n, input logic pos);
    repeat (n) line.send(pos);
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  // Let stretch expire before the latches are cleared
  task automatic clr;
    repeat (10) @(posedge sys_clk_i);
    clr_req <= 1'b1;
    @(posedge sys_clk_i);
    clr_req <= 1'b0;
    #1;
  endtask

  // Mid-run reset; earlier scenarios leave the register part filled
  task automatic reset_dut;
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check(bal, 5'h00);
    check({3'h0, pos_abs, neg_abs}, 5'h00);
  endtask

  // Fill with ones from stage one, then overflow at stage five
  task automatic t_fill;
    reset_dut;
    clr;
    for (int i = 1; i <= 5; i++)
    begin
      pulses(1, 1'b1);
      check(bal, 5'h1F >> (5 - i));
    end
    check({4'h0, err_seen}, 5'h00);
    pulses(1, 1'b1);
    check({4'h0, err_seen}, 5'h01);
  endtask

  // Drain with zeros from stage five, then underflow at stage one
  task automatic t_drain;
    clr;
    for (int i = 1; i <= 5; i++)
    begin
      pulses(1, 1'b0);
      check(bal, 5'h1F >> i);
    end
    check({4'h0, neg_abs}, 5'h00);
    check({3'h0, err_seen, str_seen}, 5'h00);
    pulses(1, 1'b0);
    check({3'h0, err_seen, str_seen}, 5'h03);
    repeat (8) @(posedge sys_clk_i);
    #1;
    check({4'h0, str_err}, 5'h00);
  endtask

  // Quiet line raises both absence flags; a positive pulse clears one
  task automatic t_absent;
    repeat (80) @(posedge sys_clk_i);
    #1;
    check({3'h0, pos_abs, neg_abs}, 5'h03);
    pulses(1, 1'b1);
    check({3'h0, pos_abs, neg_abs}, 5'h01);
  endtask

  // Enable low hides a pulse entirely; register must not move
  task automatic t_freeze;
    @(posedge sys_clk_i);
    ce <= 1'b0;
    pulses(1, 1'b1);
    check(bal, 5'h00);
    @(posedge sys_clk_i);
    ce <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    #1;
    check(bal, 5'h00);
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    ce    = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check(bal, 5'h00);
    t_absent;
    t_fill;
    t_drain;
    t_freeze;
    complete_run;
  end

  // Whole run needs well under 1000 cycles
  initial
  begin
    repeat (3000) @(posedge sys_clk_i);
    fail_count++;
    complete_run;
  end
endmodule
